// ### core/tvo_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion from the overlay generator module only
`ifndef TVO_REGS_SVH
`define TVO_REGS_SVH
`define TVO_OFS_CTRL        4'h0
`define TVO_OFS_VPLACE      4'h1
`define TVO_OFS_MESH_COL    4'h4
`define TVO_OFS_SECOND      4'h8
`define TVO_OFS_ROWMESH     4'hA
`define TVO_OFS_IRQ_STAT    4'hC
`define TVO_OFS_IRQ_MASK    4'hD
`define TVO_CTRL_RST        8'h00
`define TVO_VPLACE_RST      8'h00
`define TVO_SECOND_RST      8'h00
`define TVO_ROWMESH_RST     8'h00
`define TVO_CTRL_EN_BIT     7
`define TVO_CTRL_SIZE_BIT   3
`define TVO_VP_SIZE_BIT     6
`define TVO_SC_PEND_BIT     6
`define TVO_RM_HALF_BIT     3
`define TVO_RM_MESH_BIT     0
`define TVO_VSTART_BASE     10'h006
`define TVO_SCREEN_OFS      7'h03
`define TVO_ROWS            4'hA
`define TVO_COLS            5'h18
`define TVO_GLYPH_W         4'hE
`define TVO_GLYPH_H         5'h12
`define TVO_HSTART_DOTS     9'h040
`endif

// ### core/tvo_pkg.sv
// Types shared by the overlay generator
// Assumes no surroundings beyond the compiler
package tvo_pkg;
  typedef enum logic [1:0]
  {
    TVO_IDLE   = 2'b00,
    TVO_WAIT   = 2'b01,
    TVO_ACTIVE = 2'b10,
    TVO_DONE   = 2'b11
  } tvo_vstate_type;
  typedef logic [7:0] tvo_byte_type;
endpackage

// ### core/tvo_half_delay.sv
// Half-period delay line for the blanking signal
// Assumes one clock; both edges sample, giving 0.5 period resolution
module tvo_half_delay
  import tvo_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       din,
  input  wire logic [3:0] code,
  output logic            dout
);
  logic [7:0] pos_r;
  logic [7:0] neg_r;
  logic       pos_sel;
  logic       neg_sel;
  // Rising-edge taps, whole periods
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      pos_r <= 8'h00;
    else
      pos_r <= {pos_r[6:0], din};
  end
  // Falling-edge taps: tap k lags the input by k and a half periods
  always_ff @(negedge clock or negedge arst_n)
  begin
    if (!arst_n)
      neg_r <= 8'h00;
    else
      neg_r <= {neg_r[6:0], din};
  end
  // Even code takes whole taps, odd code takes half taps
  always_comb
  begin
    pos_sel = (code[3:1] == 3'h0) ? din : pos_r[code[3:1] - 3'h1];
    neg_sel = neg_r[code[3:1]];
  end
  assign dout = code[0] ? neg_sel : pos_sel;
endmodule

// ### core/tvo_overlay.sv
// Character overlay generator: sync lock, placement, colour, blanking
// Assumes synchronous sync inputs and a glyph source outside the block
//------------------------------------------------------------------
//------------------------------------------------------------------
`include "tvo_regs.svh"
module tvo_overlay
  import tvo_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       hsync,
  input  wire logic       vsync,
  input  wire logic       glyph_dot,
  input  wire logic [2:0] char_colour,
  input  wire logic       irq_done,
  output logic      [8:0] glyph_index_r,
  output logic      [4:0] glyph_line_r,
  output logic      [3:0] glyph_col_r,
  output logic      [3:0] cell_row_r,
  output logic      [4:0] cell_col_r,
  output logic            red_r,
  output logic            green_r,
  output logic            blue_r,
  output logic            overlay_blank_out,
  output logic            halftone_r,
  output logic            irq_r
);
  //------------------------------------------------------------------
  // Registers
  //------------------------------------------------------------------
  tvo_byte_type   overlay_control_r;
  tvo_byte_type   vertical_placement_r;
  tvo_byte_type   mesh_first_column_r;
  tvo_byte_type   second_colour_place_r;
  tvo_byte_type   row_mesh_blank_delay_r;
  logic     [1:0] irq_stat_r;
  logic     [1:0] irq_mask_r;
  tvo_vstate_type vstate_r;
  logic     [9:0] line_r;
  logic     [8:0] dot_r;
  logic     [5:0] row_line_r;
  logic     [3:0] dot_in_cell_r;
  logic           hs_d_r;
  logic           vs_d_r;
  logic           mesh_row_r;
  logic           blank_pre_r;
  logic           in_service_r;
  logic     [1:0] pend_r;
  logic     [9:0] vstart;
  logic           dbl_h;
  logic           dbl_w;
  logic           hs_rise;
  logic           vs_rise;
  logic           h_active;
  logic     [6:0] half_col;
  logic     [6:0] second_at;
  logic     [5:0] row_lines;
  logic     [3:0] cell_dots;
  // Sync edges
  assign hs_rise = hsync & ~hs_d_r;
  assign vs_rise = vsync & ~vs_d_r;
  // Start line: six plus four per step
  assign vstart = `TVO_VSTART_BASE
                + {2'b00, vertical_placement_r[5:0], 2'b00};
  // Size bit read against control bit 3
  always_comb
  begin
    if (!overlay_control_r[`TVO_CTRL_SIZE_BIT])
    begin
      dbl_h = vertical_placement_r[`TVO_VP_SIZE_BIT];
      dbl_w = 1'b0;
    end
    else
    begin
      dbl_h = ~vertical_placement_r[`TVO_VP_SIZE_BIT];
      dbl_w = 1'b1;
    end
  end
  assign row_lines = dbl_h ? {`TVO_GLYPH_H, 1'b0} : {1'b0, `TVO_GLYPH_H};
  assign cell_dots = `TVO_GLYPH_W;
  assign h_active  = (dot_r >= `TVO_HSTART_DOTS)
                   && (cell_col_r < `TVO_COLS);
  // Half-column count plus screen offset of three
  assign half_col  = {1'b0, cell_col_r, 1'b0}
                   + {6'h00, dot_in_cell_r >= 4'h7}
                   + `TVO_SCREEN_OFS;
  assign second_at = {1'b0, second_colour_place_r[5:0]};
  //------------------------------------------------------------------
  // Register bus
  //------------------------------------------------------------------
  // Writes; reserved bit 7 of placement regs stays zero
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      overlay_control_r      <= `TVO_CTRL_RST;
      vertical_placement_r   <= `TVO_VPLACE_RST;
      mesh_first_column_r    <= 8'h00;
      second_colour_place_r  <= `TVO_SECOND_RST;
      row_mesh_blank_delay_r <= `TVO_ROWMESH_RST;
      irq_mask_r             <= 2'h0;
    end
    else if (wr)
    begin
      unique case (addr)
        `TVO_OFS_CTRL:     overlay_control_r <= wdata;
        `TVO_OFS_VPLACE:   vertical_placement_r <= {1'b0, wdata[6:0]};
        `TVO_OFS_MESH_COL: mesh_first_column_r <= {3'h0, wdata[4:0]};
        `TVO_OFS_SECOND:   second_colour_place_r <= {1'b0, wdata[6:0]};
        `TVO_OFS_ROWMESH:  row_mesh_blank_delay_r <= wdata;
        `TVO_OFS_IRQ_MASK: irq_mask_r <= wdata[1:0];
        default:           ;
      endcase
    end
  end
  // Read data one cycle after the strobe, zero for unmapped
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= 8'h00;
    else if (rd)
    begin
      unique case (addr)
        `TVO_OFS_CTRL:     rdata <= overlay_control_r;
        `TVO_OFS_VPLACE:   rdata <= vertical_placement_r;
        `TVO_OFS_MESH_COL: rdata <= mesh_first_column_r;
        `TVO_OFS_SECOND:   rdata <= second_colour_place_r;
        `TVO_OFS_ROWMESH:  rdata <= row_mesh_blank_delay_r;
        `TVO_OFS_IRQ_STAT: rdata <= {4'h0, pend_r, irq_stat_r};
        `TVO_OFS_IRQ_MASK: rdata <= {6'h00, irq_mask_r};
        default:           rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end
  //------------------------------------------------------------------
  // Sync lock and counters
  //------------------------------------------------------------------
  // Edge detect registers; reset low, so a vsync already high after reset gives an edge
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      {hs_d_r, vs_d_r} <= 2'h0;
    else
      {hs_d_r, vs_d_r} <= {hsync, vsync};
  end
  // Line counter restarts on vertical sync, dot counter on horizontal
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line_r <= 10'h000;
      dot_r  <= 9'h000;
    end
    else
    begin
      if (vs_rise)
        line_r <= 10'h000;
      else if (hs_rise && line_r != 10'h3FF)
        line_r <= line_r + 10'h001;
      if (hs_rise)
        dot_r <= 9'h000;
      else if (dot_r != 9'h1FF)
        dot_r <= dot_r + 9'h001;
    end
  end
  // Vertical state: wait for start line, then walk the rows
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vstate_r   <= TVO_IDLE;
      row_line_r <= 6'h00;
      cell_row_r <= 4'h0;
      mesh_row_r <= 1'b0;
    end
    else if (vs_rise)
    begin
      vstate_r   <= overlay_control_r[`TVO_CTRL_EN_BIT] ? TVO_WAIT : TVO_IDLE;
      row_line_r <= 6'h00;
      cell_row_r <= 4'h0;
    end
    else if (hs_rise)
    begin
      unique case (vstate_r)
        TVO_IDLE, TVO_DONE: ;
        TVO_WAIT:
          if (line_r + 10'h001 == vstart)
          begin
            vstate_r   <= TVO_ACTIVE;
            mesh_row_r <= row_mesh_blank_delay_r[`TVO_RM_MESH_BIT];
          end
        TVO_ACTIVE:
          if (row_line_r + 6'h01 == row_lines)
          begin
            row_line_r <= 6'h00;
            // Mesh bit is taken for the next row only
            mesh_row_r <= row_mesh_blank_delay_r[`TVO_RM_MESH_BIT];
            if (cell_row_r + 4'h1 == `TVO_ROWS)
              vstate_r <= TVO_DONE;
            else
              cell_row_r <= cell_row_r + 4'h1;
          end
          else
            row_line_r <= row_line_r + 6'h01;
      endcase
    end
  end
  // Column and dot within cell; double width halves the dot rate
  logic wide_ph_r;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cell_col_r    <= 5'h00;
      dot_in_cell_r <= 4'h0;
      wide_ph_r     <= 1'b0;
    end
    else if (hs_rise || dot_r < `TVO_HSTART_DOTS)
    begin
      cell_col_r    <= 5'h00;
      dot_in_cell_r <= 4'h0;
      wide_ph_r     <= 1'b0;
    end
    else if (h_active)
    begin
      wide_ph_r <= dbl_w ? ~wide_ph_r : 1'b0;
      if (!dbl_w || wide_ph_r)
      begin
        if (dot_in_cell_r + 4'h1 == cell_dots)
        begin
          dot_in_cell_r <= 4'h0;
          cell_col_r    <= cell_col_r + 5'h01;
        end
        else
          dot_in_cell_r <= dot_in_cell_r + 4'h1;
      end
    end
  end
  // Glyph fetch address towards character memory
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      {glyph_index_r, glyph_line_r, glyph_col_r} <= 18'h00000;
    else
    begin
      glyph_index_r <= {cell_row_r, cell_col_r};
      glyph_line_r  <= dbl_h ? row_line_r[5:1] : row_line_r[4:0];
      glyph_col_r   <= dot_in_cell_r;
    end
  end
  //------------------------------------------------------------------
  // Pixel outputs
  //------------------------------------------------------------------
  // Foreground dots take the cell colour; past the bar it is inverted
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {red_r, green_r, blue_r} <= 3'h0;
      blank_pre_r <= 1'b0;
      halftone_r  <= 1'b0;
    end
    else
    begin
      logic on;
      on = (vstate_r == TVO_ACTIVE) && h_active && glyph_dot;
      blank_pre_r <= on;
      if (on && second_at != 7'h00 && half_col >= second_at)
        {red_r, green_r, blue_r} <= ~char_colour;
      else if (on)
        {red_r, green_r, blue_r} <= char_colour;
      else
        {red_r, green_r, blue_r} <= 3'h0;
      // Foreground joins halftone only when bit 3 set
      halftone_r <= mesh_row_r && (vstate_r == TVO_ACTIVE) && h_active
                  && (!glyph_dot
                      || row_mesh_blank_delay_r[`TVO_RM_HALF_BIT]);
    end
  end
  // Blank output delayed in half-dot steps
  // No retiming flop after the taps: it would round odd codes up and
  // put code zero a dot behind the pixels.
  tvo_half_delay u_blank_delay
  (
    .clock  (clock),
    .arst_n (arst_n),
    .din    (blank_pre_r),
    .code   (row_mesh_blank_delay_r[7:4]),
    .dout   (overlay_blank_out)
  );
  //------------------------------------------------------------------
  // Interrupts
  //------------------------------------------------------------------
  // Bit0 horizontal row start, bit1 vertical; set beats read clear.
  // A request arriving in service is held only with the option set.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_stat_r   <= 2'h0;
      pend_r       <= 2'h0;
      in_service_r <= 1'b0;
    end
    else
    begin
      logic [1:0] ev;
      logic [1:0] go;
      ev = {vs_rise, hs_rise && vstate_r == TVO_ACTIVE
                     && row_line_r == 6'h00};
      go = 2'h0;
      if (!in_service_r)
      begin
        go = ev | pend_r;
        pend_r <= 2'h0;
      end
      else if (second_colour_place_r[`TVO_SC_PEND_BIT])
        pend_r <= pend_r | ev;
      else
        pend_r <= 2'h0;
      if (go != 2'h0)
        in_service_r <= 1'b1;
      else if (irq_done)
        in_service_r <= 1'b0;
      if (rd && addr == `TVO_OFS_IRQ_STAT)
        irq_stat_r <= go;
      else
        irq_stat_r <= irq_stat_r | go;
    end
  end
  // Level interrupt from unmasked status
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_stat_r & irq_mask_r);
  end
endmodule

// ### bench/tvo_overlay_properties.sv
// Concurrent checks on the overlay generator's ports
// Assumes a bind onto tvo_overlay: one dot clock, async active-low reset
//----------------------------------------------------------------
// Port checks
//----------------------------------------------------------------
module tvo_overlay_properties
  import tvo_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic [7:0] rdata,
  input  wire logic       hsync,
  input  wire logic       vsync,
  input  wire logic       red_r,
  input  wire logic       green_r,
  input  wire logic       blue_r,
  input  wire logic       overlay_blank_out,
  input  wire logic       irq_r
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] code_r;
  logic [4:0] quiet_r;
  logic [3:0] line_r;
  logic       hs_d_r;
  logic       vs_d_r;
  logic       pix;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // Shadow delay code; a fresh code needs settling before blank is judged
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      code_r  <= 4'h0;
      quiet_r <= 5'h00;
    end
    else if (wr && addr == 4'hA)
    begin
      code_r  <= wdata[7:4];
      quiet_r <= 5'h00;
    end
    else if (quiet_r != 5'h1F)
      quiet_r <= quiet_r + 5'h01;
  end
  // Lines since the last vsync edge, held at fifteen
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hs_d_r <= 1'b0;
      vs_d_r <= 1'b0;
      line_r <= 4'h0;
    end
    else
    begin
      hs_d_r <= hsync;
      vs_d_r <= vsync;
      if (vsync && !vs_d_r)
        line_r <= 4'h0;
      else if (hsync && !hs_d_r && line_r != 4'hF)
        line_r <= line_r + 4'h1;
    end
  end
  assign pix = red_r | green_r | blue_r;
  read_idle_a:
    assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside a read answer");
  unmapped_zero_a:
    assert property (rd && addr == 4'h3 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
  vplace_back_a:
    assert property (wr && addr == 4'h1 ##2 rd && addr == 4'h1 |=>
      rdata == ($past(wdata, 3) & 8'h7F))
      else $error("placement readback wrong");
  colour_back_a:
    assert property (wr && addr == 4'h8 ##2 rd && addr == 4'h8 |=>
      rdata == ($past(wdata, 3) & 8'h7F))
      else $error("second colour readback wrong");
  row_back_a:
    assert property (wr && addr == 4'hA ##2 rd && addr == 4'hA |=>
      rdata == $past(wdata, 3))
      else $error("row register readback wrong");
  reset_quiet_a:
    assert property ($rose(arst_n) |->
      rdata == 8'h00 && !irq_r && !overlay_blank_out)
      else $error("outputs busy after reset");
  blank_cover_a:
    assert property (pix && quiet_r[4] && code_r == 4'h0 |-> overlay_blank_out)
      else $error("pixel shown without blank");
  blank_one_a:
    assert property (quiet_r[4] && code_r == 4'h2 && $past(pix) |->
      overlay_blank_out)
      else $error("blank not one dot late");
  blank_seven_a:
    assert property (quiet_r[4] && code_r == 4'hE && $past(pix, 7) |->
      overlay_blank_out)
      else $error("blank not seven dots late");
  top_gap_a:
    assert property (line_r != 4'h0 && line_r < 4'h5 |-> !overlay_blank_out)
      else $error("overlay above top position");
endmodule

bind tvo_overlay tvo_overlay_properties tvo_overlay_properties_i
(
  .clock, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .hsync, .vsync,
  .red_r, .green_r, .blue_r, .overlay_blank_out, .irq_r
);

// ### bench/tvo_video_model.sv
// Video side model: sync source and glyph data for the overlay
// Assumes the dot clock and active-low reset of the overlay
//----------------------------------------------------------------
// Sync and glyph model
//----------------------------------------------------------------
module tvo_video_model
  import tvo_pkg::*;
#(
  parameter int LINE_DOTS = 440
)
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       field_req,
  input  wire logic [4:0] cell_col_r,
  output logic            hsync,
  output logic            vsync,
  output logic            glyph_dot,
  output logic [2:0]      char_colour
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0]  dot_r;
  logic [10:0] vs_left_r;
  logic        pend_r;
  // Free-running dots; a line is long enough for all columns at single width only
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      dot_r <= 9'h000;
    else if (dot_r == 9'(LINE_DOTS - 1))
      dot_r <= 9'h000;
    else
      dot_r <= dot_r + 9'h001;
  end
  // Field starts mid-line so the two sync edges never coincide
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_r    <= 1'b0;
      vs_left_r <= 11'h000;
    end
    else if (pend_r && dot_r == 9'h0C8)
    begin
      pend_r    <= 1'b0;
      vs_left_r <= 11'(3 * LINE_DOTS);
    end
    else
    begin
      pend_r    <= pend_r | field_req;
      vs_left_r <= vs_left_r - 11'(vs_left_r != 11'h000);
    end
  end
  // Sync levels; the rising edge is the event
  assign hsync = dot_r < 9'h008;
  assign vsync = vs_left_r != 11'h000;
  // Every dot foreground and never black, so each cell shows
  assign glyph_dot   = 1'b1;
  assign char_colour = {cell_col_r[1:0], 1'b1};
endmodule

// ### bench/test_tv_onscreen_display_overlay.sv
// Self-checking bench for the overlay generator
// Assumes the video model supplies syncs and glyph data
module test_tv_onscreen_display_overlay
  import tvo_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock, arst_n, wr, rd, hsync, vsync, glyph_dot, irq_r;
  logic       irq_done, blank, field_req, armed, i0, i1, ht;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, q;
  logic [2:0] char_colour;
  logic [4:0] cell_col;
  int         err_count, n_checks, hs_n, got_n, t0, n, t;
  real        t_hs, got_t;
  logic [3:0] ra [3] = '{4'h1, 4'h8, 4'hA};
  logic [3:0] ta [5] = '{4'h1, 4'h8, 4'hA, 4'h4, 4'h3};
  logic [7:0] tw [5] = '{8'hFF, 8'hC5, 8'hF9, 8'h15, 8'hAA};
  logic [7:0] te [5] = '{8'h7F, 8'h45, 8'hF9, 8'h15, 8'h00};
  logic [7:0] tm [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF};
  logic [7:0] vp [3] = '{8'h01, 8'h02, 8'h03};

  tvo_overlay tvo_overlay_i
  (
    .clock, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .hsync, .vsync,
    .glyph_dot, .char_colour, .irq_done, .glyph_index_r(), .glyph_line_r(),
    .glyph_col_r(), .cell_row_r(), .cell_col_r(cell_col), .red_r(),
    .green_r(), .blue_r(), .overlay_blank_out(blank), .halftone_r(ht), .irq_r
  );
  tvo_video_model tvo_video_model_i
  (
    .clock, .arst_n, .field_req, .cell_col_r(cell_col), .hsync, .vsync,
    .glyph_dot, .char_colour
  );

  // 40 MHz dot clock
  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  // Lines and time from sync to the first blank edge of a field
  always @(posedge vsync)
  begin
    hs_n  = 0;
    armed = 1'b1;
  end
  always @(posedge hsync)
  begin
    hs_n = hs_n + 1;
    t_hs = $realtime;
  end
  always @(posedge blank)
    if (armed)
    begin
      armed = 1'b0;
      got_n = hs_n;
      got_t = $realtime - t_hs;
    end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One strobe cycle; read data is taken in the cycle after
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    wr    <= w;
    rd    <= ~w;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clock);
    r = rdata;
    @(posedge clock);
  endtask

  // Request a field and wait, bounded, for its first blank edge
  task automatic field(output int nl, output int tt);
    int k;
    got_n = -1;
    field_req <= 1'b1;
    @(posedge clock);
    field_req <= 1'b0;
    for (k = 0; k < 40000 && got_n < 0; k++)
      @(posedge clock);
    nl = got_n;
    tt = int'(got_t * 10.0);
    if (got_n < 0)
    begin
      err_count++;
      $display("BAD %0t no overlay seen", $time);
      close_out;
    end
  endtask

  // Let a mask change land, then sample the interrupt level
  task automatic settle(output logic v);
    repeat (2) @(posedge clock);
    @(negedge clock);
    v = irq_r;
    @(posedge clock);
  endtask

  initial
  begin
    {arst_n, addr, wdata, wr, rd, irq_done, field_req, armed} = '0;
    err_count = 0;
    n_checks  = 0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    // Reset values, then readback including reserved and unmapped places
    foreach (ra[i])
    begin
      acc(1'b0, ra[i], 8'h00, q);
      chk(16'(q), 16'h0000);
    end
    foreach (ta[i])
    begin
      acc(1'b1, ta[i], tw[i], q);
      acc(1'b0, ta[i], 8'h00, q);
      chk(16'(q & tm[i]), 16'(te[i]));
    end
    acc(1'b1, 4'h8, 8'h00, q);
    acc(1'b1, 4'hA, 8'h00, q);
    acc(1'b1, 4'h0, 8'h80, q);
    // Start line is six plus four per step; steps keep to line ten up
    foreach (vp[i])
    begin
      acc(1'b1, 4'h1, vp[i], q);
      field(n, t);
      if (i == 0)
        t0 = t;
      chk(16'(n), 16'(6 + 4 * vp[i]));
    end
    acc(1'b1, 4'h1, 8'h00, q);
    // Every delay code moves blank by half a dot per step
    for (int c = 1; c < 16; c++)
    begin
      acc(1'b1, 4'hA, {4'(c), 4'h0}, q);
      field(n, t);
      chk(16'(n), 16'h0006);
      chk(16'(t - t0), 16'(c * 125));
    end
    // Mask polarity flips the level; status read clears the sync event
    acc(1'b1, 4'hD, 8'h00, q);
    settle(i0);
    acc(1'b1, 4'hD, 8'hFF, q);
    settle(i1);
    chk(16'(i0 ^ i1), 16'h0001);
    irq_done <= 1'b1;
    @(posedge clock);
    irq_done <= 1'b0;
    acc(1'b0, 4'hC, 8'h00, q);
    chk(16'(q & 8'h02), 16'h0002);
    acc(1'b0, 4'hC, 8'h00, q);
    chk(16'(q & 8'h02), 16'h0000);
    // Mesh row with foreground in halftone, then foreground left out
    acc(1'b1, 4'h8, 8'h40, q);
    acc(1'b1, 4'hA, 8'h09, q);
    field(n, t);
    @(negedge clock);
    chk(16'(ht), 16'h0001);
    @(posedge clock);
    acc(1'b1, 4'hA, 8'h01, q);
    @(negedge clock);
    chk(16'(ht), 16'h0000);
    // A row start met in service is held only with the option set
    repeat (500) @(posedge clock);
    acc(1'b0, 4'hC, 8'h00, q);
    chk(16'(q & 8'h04), 16'h0004);
    acc(1'b1, 4'h8, 8'h00, q);
    acc(1'b0, 4'hC, 8'h00, q);
    chk(16'(q & 8'h0C), 16'h0000);
    close_out;
  end
endmodule
